/* core/ifs_pkg.sv */
// Shared constants for the interrupt flag status block
package ifs_pkg;
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int FLAG_W   = 13;
   localparam int SAMPLE_W = 16;
   localparam int CUSTOM_N = 4;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_FLAGS_A = 32'h0000_3010;
   localparam logic [ADDR_W-1:0] OFS_FLAGS_B = 32'h0000_3014;
   localparam logic [ADDR_W-1:0] OFS_CLEAR_A = 32'h0000_3018;
   localparam logic [ADDR_W-1:0] OFS_CLEAR_B = 32'h0000_301c;
   localparam logic [ADDR_W-1:0] OFS_DELTA   = 32'h0000_3020;
   localparam logic [ADDR_W-1:0] OFS_UPPER   = 32'h0000_3024;
   localparam logic [ADDR_W-1:0] OFS_LOWER   = 32'h0000_3028;

   // Flag bit positions
   localparam int BIT_CONV    = 0;
   localparam int BIT_FOURIER = 1;
   localparam int BIT_SINC2   = 2;
   localparam int BIT_TEMP    = 3;
   localparam int BIT_LOWER   = 4;
   localparam int BIT_UPPER   = 5;
   localparam int BIT_DELTA   = 6;
   localparam int BIT_MEAN    = 7;
   localparam int BIT_VAR     = 8;
   localparam int BIT_CUSTOM0 = 9;

   // Reset values
   localparam logic [FLAG_W-1:0]   RST_FLAGS = 13'h0000;
   localparam logic [SAMPLE_W-1:0] RST_DELTA = 16'hffff;
   localparam logic [SAMPLE_W-1:0] RST_UPPER = 16'hffff;
   localparam logic [SAMPLE_W-1:0] RST_LOWER = 16'h0000;
   localparam logic [DATA_W-1:0]   RST_RDATA = 32'h0000_0000;
endpackage : ifs_pkg

/* core/ifs_sticky_flags.sv */
// Vector of sticky flags: set wins over clear
`timescale 1ns/10ps
module ifs_sticky_flags #(
   parameter int W = 13
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clear_i,
   output logic      [W-1:0] flags_o
);
   typedef struct packed {
      logic [W-1:0] flags;
   } ifs_sticky_state_t;

   ifs_sticky_state_t st;
   ifs_sticky_state_t next_st;

   always_comb begin
      next_st = st;
      // An event in the clearing cycle survives
      next_st.flags = (st.flags & ~clear_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags_o = st.flags;
endmodule : ifs_sticky_flags

/* core/ifs_limit_check.sv */
// Conversion limit checks: delta, upper and lower
`timescale 1ns/10ps
module ifs_limit_check #(
   parameter int SW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic          sample_valid_i,
   input  wire logic [SW-1:0] sample_i,
   input  wire logic [SW-1:0] delta_limit_i,
   input  wire logic [SW-1:0] upper_limit_i,
   input  wire logic [SW-1:0] lower_limit_i,
   output logic               delta_fail_o,
   output logic               upper_fail_o,
   output logic               lower_fail_o
);
   typedef struct packed {
      logic [SW-1:0] prev;
      logic          have_prev;
      logic          delta_fail;
      logic          upper_fail;
      logic          lower_fail;
   } ifs_limit_state_t;

   ifs_limit_state_t st;
   ifs_limit_state_t next_st;
   logic [SW-1:0]    diff;

   always_comb begin
      next_st = st;
      diff = (sample_i >= st.prev) ? sample_i - st.prev : st.prev - sample_i;
      next_st.delta_fail = sample_valid_i && st.have_prev && (diff > delta_limit_i);
      next_st.upper_fail = sample_valid_i && (sample_i > upper_limit_i);
      next_st.lower_fail = sample_valid_i && (sample_i < lower_limit_i);
      if (sample_valid_i) begin
         next_st.prev = sample_i;
         next_st.have_prev = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign delta_fail_o = st.delta_fail;
   assign upper_fail_o = st.upper_fail;
   assign lower_fail_o = st.lower_fail;
endmodule : ifs_limit_check

/* core/ifs_irq_flags.sv */
// Interrupt flag status block, low thirteen bits, with register port
// Contract
// - Custom interrupts 3..0 show in flag bits 12..9, one meaning asserted.
// - Bit 6 sets when two successive conversions differ by more than the delta limit.
// - Bit 6 stays set until cleared and reads zero only if no delta violation since.
// - Bit 5 sets when a conversion is above the upper limit.
// - Bit 4 sets when a conversion is below the lower limit.
// - Bit 4 is sticky and reads zero only if no low result since the last clear.
// - Bit 3 sets when a temperature result is available.
// - Bit 2 sets when the sinc2 filter has a new result.
// - Bit 1 sets when the Fourier engine has a new result.
// - Bit 0 sets when a new conversion result is available.
// - Two flag registers with the same layout and sources stand at two addresses.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module ifs_irq_flags (
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   input  wire logic [ifs_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic [ifs_pkg::DATA_W-1:0]    wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic      [ifs_pkg::DATA_W-1:0]    rdata_o,
   input  wire logic [ifs_pkg::CUSTOM_N-1:0]  custom_irq_i,
   input  wire logic                          variance_ready_i,
   input  wire logic                          mean_ready_i,
   input  wire logic                          temperature_ready_i,
   input  wire logic                          sinc2_ready_i,
   input  wire logic                          fourier_ready_i,
   input  wire logic                          conversion_ready_i,
   input  wire logic [ifs_pkg::SAMPLE_W-1:0]  conversion_data_i,
   output logic      [ifs_pkg::FLAG_W-1:0]    irq_flags_a_o,
   output logic      [ifs_pkg::FLAG_W-1:0]    irq_flags_b_o
);
   typedef struct packed {
      logic [ifs_pkg::DATA_W-1:0]   rdata;
      logic [ifs_pkg::SAMPLE_W-1:0] delta_limit_value;
      logic [ifs_pkg::SAMPLE_W-1:0] upper_limit_value;
      logic [ifs_pkg::SAMPLE_W-1:0] lower_limit_value;
      logic [ifs_pkg::SAMPLE_W-1:0] ast_prev;
      logic                         ast_have;
   } ifs_top_state_t;

   localparam ifs_top_state_t ST_RESET = '{
      rdata:             ifs_pkg::RST_RDATA,
      delta_limit_value: ifs_pkg::RST_DELTA,
      upper_limit_value: ifs_pkg::RST_UPPER,
      lower_limit_value: ifs_pkg::RST_LOWER,
      ast_prev:          '0,
      ast_have:          1'b0
   };

   localparam int PAD_W = ifs_pkg::DATA_W - ifs_pkg::FLAG_W;
   localparam int LIM_PAD_W = ifs_pkg::DATA_W - ifs_pkg::SAMPLE_W;

   ifs_top_state_t             st;
   ifs_top_state_t             next_st;
   logic                       delta_fail;
   logic                       upper_fail;
   logic                       lower_fail;
   logic [ifs_pkg::FLAG_W-1:0] flag_set;
   logic [ifs_pkg::FLAG_W-1:0] clear_a;
   logic [ifs_pkg::FLAG_W-1:0] clear_b;
   logic [ifs_pkg::FLAG_W-1:0] flags_a;
   logic [ifs_pkg::FLAG_W-1:0] flags_b;
   logic [ifs_pkg::SAMPLE_W-1:0] ast_diff;

   ifs_limit_check #(
      .SW (ifs_pkg::SAMPLE_W)
   ) u_limit (
      .clk_i          (clk_i),
      .reset_i        (reset_i),
      .sample_valid_i (conversion_ready_i),
      .sample_i       (conversion_data_i),
      .delta_limit_i  (st.delta_limit_value),
      .upper_limit_i  (st.upper_limit_value),
      .lower_limit_i  (st.lower_limit_value),
      .delta_fail_o   (delta_fail),
      .upper_fail_o   (upper_fail),
      .lower_fail_o   (lower_fail)
   );

   // One event vector feeds both registers so they never disagree on sources
   always_comb begin
      flag_set = '0;
      flag_set[ifs_pkg::BIT_CUSTOM0 +: ifs_pkg::CUSTOM_N] = custom_irq_i;
      flag_set[ifs_pkg::BIT_VAR]     = variance_ready_i;
      flag_set[ifs_pkg::BIT_MEAN]    = mean_ready_i;
      flag_set[ifs_pkg::BIT_DELTA]   = delta_fail;
      flag_set[ifs_pkg::BIT_UPPER]   = upper_fail;
      flag_set[ifs_pkg::BIT_LOWER]   = lower_fail;
      flag_set[ifs_pkg::BIT_TEMP]    = temperature_ready_i;
      flag_set[ifs_pkg::BIT_SINC2]   = sinc2_ready_i;
      flag_set[ifs_pkg::BIT_FOURIER] = fourier_ready_i;
      flag_set[ifs_pkg::BIT_CONV]    = conversion_ready_i;
   end

   assign clear_a = (wr_i && addr_i == ifs_pkg::OFS_CLEAR_A) ? wdata_i[ifs_pkg::FLAG_W-1:0] : '0;
   assign clear_b = (wr_i && addr_i == ifs_pkg::OFS_CLEAR_B) ? wdata_i[ifs_pkg::FLAG_W-1:0] : '0;

   // Each register keeps its own sticky copy so each can be cleared alone
   ifs_sticky_flags #(
      .W (ifs_pkg::FLAG_W)
   ) u_flags_a (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .set_i   (flag_set),
      .clear_i (clear_a),
      .flags_o (flags_a)
   );

   ifs_sticky_flags #(
      .W (ifs_pkg::FLAG_W)
   ) u_flags_b (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .set_i   (flag_set),
      .clear_i (clear_b),
      .flags_o (flags_b)
   );

   always_comb begin
      next_st = st;
      next_st.rdata = '0;
      // Flag registers accept no write; only the clear addresses touch them
      if (wr_i) begin
         if (addr_i == ifs_pkg::OFS_DELTA) begin
            next_st.delta_limit_value = wdata_i[ifs_pkg::SAMPLE_W-1:0];
         end else if (addr_i == ifs_pkg::OFS_UPPER) begin
            next_st.upper_limit_value = wdata_i[ifs_pkg::SAMPLE_W-1:0];
         end else if (addr_i == ifs_pkg::OFS_LOWER) begin
            next_st.lower_limit_value = wdata_i[ifs_pkg::SAMPLE_W-1:0];
         end
      end
      if (rd_i) begin
         if (addr_i == ifs_pkg::OFS_FLAGS_A) begin
            next_st.rdata = {{PAD_W{1'b0}}, flags_a};
         end else if (addr_i == ifs_pkg::OFS_FLAGS_B) begin
            next_st.rdata = {{PAD_W{1'b0}}, flags_b};
         end else if (addr_i == ifs_pkg::OFS_DELTA) begin
            next_st.rdata = {{LIM_PAD_W{1'b0}}, st.delta_limit_value};
         end else if (addr_i == ifs_pkg::OFS_UPPER) begin
            next_st.rdata = {{LIM_PAD_W{1'b0}}, st.upper_limit_value};
         end else if (addr_i == ifs_pkg::OFS_LOWER) begin
            next_st.rdata = {{LIM_PAD_W{1'b0}}, st.lower_limit_value};
         end else begin
            next_st.rdata = '0;
         end
      end
      if (conversion_ready_i) begin
         next_st.ast_prev = conversion_data_i;
         next_st.ast_have = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o       = st.rdata;
   assign irq_flags_a_o = flags_a;
   assign irq_flags_b_o = flags_b;

   // Checks below use an independent model of the previous sample
   assign ast_diff = (conversion_data_i >= st.ast_prev) ? conversion_data_i - st.ast_prev
                                                        : st.ast_prev - conversion_data_i;

   default clocking ast_cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_delta_violation;
      conversion_ready_i && st.ast_have && (ast_diff > st.delta_limit_value);
   endsequence

   sequence s_upper_violation;
      conversion_ready_i && (conversion_data_i > st.upper_limit_value);
   endsequence

   sequence s_lower_violation;
      conversion_ready_i && (conversion_data_i < st.lower_limit_value);
   endsequence

   sequence s_no_clear_a(int b);
      !(wr_i && addr_i == ifs_pkg::OFS_CLEAR_A && wdata_i[b]);
   endsequence

   sequence s_no_clear_b(int b);
      !(wr_i && addr_i == ifs_pkg::OFS_CLEAR_B && wdata_i[b]);
   endsequence

   AST_CUSTOM_TO_FLAGS: assert property (
      (custom_irq_i != '0) |=>
         ((flags_a[12:9] & $past(custom_irq_i)) == $past(custom_irq_i)))
      else $error("custom interrupt not reflected in flag bits");

   AST_DELTA_SETS: assert property (
      s_delta_violation |-> ##2 flags_a[ifs_pkg::BIT_DELTA])
      else $error("delta violation did not set its flag");

   AST_DELTA_STICKY: assert property (
      flags_a[ifs_pkg::BIT_DELTA] and s_no_clear_a(ifs_pkg::BIT_DELTA) |=> flags_a[ifs_pkg::BIT_DELTA])
      else $error("delta flag dropped without a clear");

   AST_DELTA_QUIET: assert property (
      !flags_a[ifs_pkg::BIT_DELTA] && !delta_fail |=> !flags_a[ifs_pkg::BIT_DELTA])
      else $error("delta flag rose without a violation");

   AST_UPPER_SETS: assert property (
      s_upper_violation |-> ##2 flags_a[ifs_pkg::BIT_UPPER])
      else $error("upper limit violation did not set its flag");

   AST_LOWER_SETS: assert property (
      s_lower_violation |-> ##2 (flags_a[ifs_pkg::BIT_LOWER] && flags_b[ifs_pkg::BIT_LOWER]))
      else $error("lower limit violation did not set its flag");

   AST_LOWER_STICKY: assert property (
      flags_a[ifs_pkg::BIT_LOWER] and s_no_clear_a(ifs_pkg::BIT_LOWER) |=> flags_a[ifs_pkg::BIT_LOWER])
      else $error("lower limit flag dropped without a clear");

   AST_TEMP_SETS: assert property (
      temperature_ready_i |=> flags_a[ifs_pkg::BIT_TEMP])
      else $error("temperature flag not set");

   AST_SINC2_SETS: assert property (
      sinc2_ready_i |=> flags_a[ifs_pkg::BIT_SINC2])
      else $error("sinc2 flag not set");

   AST_FOURIER_SETS: assert property (
      fourier_ready_i |=> flags_b[ifs_pkg::BIT_FOURIER])
      else $error("fourier flag not set");

   AST_CONV_SETS: assert property (
      conversion_ready_i |=> flags_a[ifs_pkg::BIT_CONV])
      else $error("conversion flag not set");

   AST_STATS_SET: assert property (
      variance_ready_i |=> flags_a[ifs_pkg::BIT_VAR])
      else $error("variance flag not set");

   AST_MEAN_SETS: assert property (
      mean_ready_i |=> flags_a[ifs_pkg::BIT_MEAN])
      else $error("mean flag not set");

   AST_RESET_ZERO: assert property (@(posedge clk_i) disable iff (1'b0)
      reset_i |=> (flags_a == ifs_pkg::RST_FLAGS) && (flags_b == ifs_pkg::RST_FLAGS))
      else $error("flags not zero after reset");

   AST_READ_A: assert property (
      rd_i && addr_i == ifs_pkg::OFS_FLAGS_A |=> rdata_o == {{PAD_W{1'b0}}, $past(flags_a)})
      else $error("read of first flag register returned wrong data");

   AST_READ_B: assert property (
      rd_i && addr_i == ifs_pkg::OFS_FLAGS_B |=> rdata_o == {{PAD_W{1'b0}}, $past(flags_b)})
      else $error("read of second flag register returned wrong data");

   AST_SAME_SOURCES: assert property (
      (flag_set != '0) |=> ((flags_a & flags_b & $past(flag_set)) == $past(flag_set)))
      else $error("flag registers disagree on a new event");

   AST_CLEAR_A_ONLY: assert property (
      wr_i && addr_i == ifs_pkg::OFS_CLEAR_A && (flag_set == '0) |=> ((flags_b & ~$past(flags_b)) == '0))
      else $error("clear of first register disturbed the second");

   AST_CUSTOM_TO_FLAGS_B: assert property (
      (custom_irq_i != '0) |=>
         ((flags_b[ifs_pkg::BIT_CUSTOM0 +: ifs_pkg::CUSTOM_N] & $past(custom_irq_i)) == $past(custom_irq_i)))
      else $error("custom interrupt not reflected in second register");

   AST_DELTA_STICKY_B: assert property (
      flags_b[ifs_pkg::BIT_DELTA] and s_no_clear_b(ifs_pkg::BIT_DELTA) |=> flags_b[ifs_pkg::BIT_DELTA])
      else $error("second delta flag dropped without a clear");

   AST_LOWER_STICKY_B: assert property (
      flags_b[ifs_pkg::BIT_LOWER] and s_no_clear_b(ifs_pkg::BIT_LOWER) |=> flags_b[ifs_pkg::BIT_LOWER])
      else $error("second lower limit flag dropped without a clear");

   AST_LOWER_QUIET: assert property (
      !flags_a[ifs_pkg::BIT_LOWER] && !lower_fail |=> !flags_a[ifs_pkg::BIT_LOWER])
      else $error("lower limit flag rose without a violation");

   AST_UPPER_STICKY: assert property (
      flags_a[ifs_pkg::BIT_UPPER] and s_no_clear_a(ifs_pkg::BIT_UPPER) |=> flags_a[ifs_pkg::BIT_UPPER])
      else $error("upper limit flag dropped without a clear");

   AST_UPPER_QUIET: assert property (
      !flags_a[ifs_pkg::BIT_UPPER] && !upper_fail |=> !flags_a[ifs_pkg::BIT_UPPER])
      else $error("upper limit flag rose without a violation");

   AST_DELTA_FIRST: assert property (
      conversion_ready_i && !st.ast_have |=> !delta_fail)
      else $error("first conversion failed the delta check");

   AST_FAIL_NEEDS_CONV: assert property (
      !conversion_ready_i |=> !(delta_fail || upper_fail || lower_fail))
      else $error("limit check failed without a conversion");

   AST_DELTA_EXACT: assert property (
      conversion_ready_i && st.ast_have && (ast_diff <= st.delta_limit_value) |=> !delta_fail)
      else $error("delta check failed inside the limit");

   AST_UPPER_EXACT: assert property (
      conversion_ready_i && (conversion_data_i <= st.upper_limit_value) |=> !upper_fail)
      else $error("upper check failed inside the limit");

   AST_LOWER_EXACT: assert property (
      conversion_ready_i && (conversion_data_i >= st.lower_limit_value) |=> !lower_fail)
      else $error("lower check failed inside the limit");

   AST_CLEAR_A_WORKS: assert property (
      wr_i && addr_i == ifs_pkg::OFS_CLEAR_A && (flag_set == '0) |=>
         ((flags_a & $past(wdata_i[ifs_pkg::FLAG_W-1:0])) == '0))
      else $error("clear of first register left a masked flag set");

   AST_CLEAR_B_WORKS: assert property (
      wr_i && addr_i == ifs_pkg::OFS_CLEAR_B && (flag_set == '0) |=>
         ((flags_b & $past(wdata_i[ifs_pkg::FLAG_W-1:0])) == '0))
      else $error("clear of second register left a masked flag set");

   AST_CLEAR_B_ONLY: assert property (
      wr_i && addr_i == ifs_pkg::OFS_CLEAR_B && (flag_set == '0) |=> ((flags_a & ~$past(flags_a)) == '0))
      else $error("clear of second register disturbed the first");

   AST_FLAGS_READ_ONLY: assert property (
      wr_i && addr_i == ifs_pkg::OFS_FLAGS_A && (flag_set == '0) |=>
         (flags_a == $past(flags_a)) && (flags_b == $past(flags_b)))
      else $error("write to a flag register changed the flags");

   AST_READ_IDLE: assert property (
      !rd_i |=> (rdata_o == '0))
      else $error("read data not zero outside a read");

   AST_READ_DELTA: assert property (
      rd_i && addr_i == ifs_pkg::OFS_DELTA |=> rdata_o == {{LIM_PAD_W{1'b0}}, $past(st.delta_limit_value)})
      else $error("read of delta limit returned wrong data");

   AST_LIMIT_WRITE: assert property (
      wr_i && addr_i == ifs_pkg::OFS_UPPER |=> st.upper_limit_value == $past(wdata_i[ifs_pkg::SAMPLE_W-1:0]))
      else $error("upper limit write did not land");

   AST_FOURIER_A: assert property (
      fourier_ready_i |=> flags_a[ifs_pkg::BIT_FOURIER])
      else $error("fourier flag of first register not set");

   AST_CONV_B: assert property (
      conversion_ready_i |=> flags_b[ifs_pkg::BIT_CONV])
      else $error("conversion flag of second register not set");
endmodule : ifs_irq_flags

/* verification/ifs_host_model.sv */
// Host model: register port master that reads and writes the flag block
`timescale 1ns/10ps
module ifs_host_model (
   input  wire logic                       clk_i,
   input  wire logic [ifs_pkg::DATA_W-1:0] rdata_i,
   output logic      [ifs_pkg::ADDR_W-1:0] addr_o,
   output logic      [ifs_pkg::DATA_W-1:0] wdata_o,
   output logic                            wr_o,
   output logic                            rd_o
);
   initial begin
      addr_o = 32'h0000_0000;
      wdata_o = 32'h0000_0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // Idle lines flip so stale values never pass
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : write_reg

   task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask : read_reg
endmodule : ifs_host_model

/* verification/ifs_irq_flags_tb.sv */
// Self-checking testbench for the interrupt flag status block
`timescale 1ns/10ps
module ifs_irq_flags_tb;
   typedef struct packed {logic [12:0] ev; logic [15:0] data; logic [12:0] exp;} ifs_row_t;
   logic        clk_i;
   logic        reset_i;
   logic [31:0] addr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic [12:0] irq_flags_a_o;
   logic [12:0] irq_flags_b_o;
   logic [12:0] ev;
   logic [15:0] sample;
   logic [31:0] rd_val;
   int          mismatches;
   int          n_checks;
   // Event bits match flag bits; bit 0 carries sample
   ifs_row_t rows [15] = '{
      '{13'h1000, 16'h0000, 13'h1000}, '{13'h0800, 16'h0000, 13'h0800},
      '{13'h0400, 16'h0000, 13'h0400}, '{13'h0200, 16'h0000, 13'h0200},
      '{13'h0100, 16'h0000, 13'h0100}, '{13'h0080, 16'h0000, 13'h0080},
      '{13'h0008, 16'h0000, 13'h0008}, '{13'h0004, 16'h0000, 13'h0004},
      '{13'h0002, 16'h0000, 13'h0002}, '{13'h0001, 16'h0050, 13'h0011},
      '{13'h0001, 16'h1001, 13'h0061}, '{13'h0001, 16'h1100, 13'h0021},
      '{13'h0001, 16'h1000, 13'h0001}, '{13'h0001, 16'h0e00, 13'h0001},
      '{13'h0001, 16'h0100, 13'h0041}};

   ifs_irq_flags DUT (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .custom_irq_i(ev[12:9]), .variance_ready_i(ev[8]), .mean_ready_i(ev[7]),
      .temperature_ready_i(ev[3]), .sinc2_ready_i(ev[2]), .fourier_ready_i(ev[1]),
      .conversion_ready_i(ev[0]), .conversion_data_i(sample),
      .irq_flags_a_o(irq_flags_a_o), .irq_flags_b_o(irq_flags_b_o));

   ifs_host_model host (
      .clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check_flags(input logic [12:0] got, input logic [12:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t flags got %h exp %h", $time, got, exp);
      end
   endtask : check_flags

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
      end
   endtask : check_word

   task automatic pulse(input logic [12:0] e, input logic [15:0] d);
      @(posedge clk_i);
      ev <= e;
      sample <= d;
      @(posedge clk_i);
      ev <= 13'h0000;
   endtask : pulse

   task automatic settle_check(input logic [12:0] ea, input logic [12:0] eb);
      // Limit flags land two edges after a conversion
      @(posedge clk_i);
      #1;
      check_flags(irq_flags_a_o, ea);
      check_flags(irq_flags_b_o, eb);
   endtask : settle_check

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   initial begin
      #200us;
      mismatches++;
      final_report();
   end

   initial begin
      mismatches = 0;
      n_checks = 0;
      reset_i = 1'b1;
      ev = 13'h0000;
      sample = 16'h0000;
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      settle_check(13'h0000, 13'h0000);
      host.read_reg(ifs_pkg::OFS_DELTA, rd_val);
      check_word(rd_val, 32'h0000_ffff);
      host.read_reg(ifs_pkg::OFS_LOWER, rd_val);
      check_word(rd_val, 32'h0000_0000);
      host.write_reg(ifs_pkg::OFS_UPPER, 32'h0000_1000);
      host.write_reg(ifs_pkg::OFS_LOWER, 32'h0000_0100);
      host.write_reg(ifs_pkg::OFS_DELTA, 32'h0000_0200);
      host.read_reg(ifs_pkg::OFS_UPPER, rd_val);
      check_word(rd_val, 32'h0000_1000);
      $display("reset test done");
      foreach (rows[i]) begin
         pulse(rows[i].ev, rows[i].data);
         settle_check(rows[i].exp, rows[i].exp);
         host.read_reg(ifs_pkg::OFS_FLAGS_B, rd_val);
         check_word(rd_val, {19'h00000, rows[i].exp});
         host.write_reg(ifs_pkg::OFS_CLEAR_A, 32'h0000_1fff);
         host.write_reg(ifs_pkg::OFS_CLEAR_B, 32'h0000_1fff);
      end
      $display("table test done");
      pulse(13'h0001, 16'h0000);
      pulse(13'h0001, 16'h0800);
      pulse(13'h0001, 16'h0810);
      repeat (5) @(posedge clk_i);
      settle_check(13'h0051, 13'h0051);
      host.write_reg(ifs_pkg::OFS_FLAGS_A, 32'hffff_ffff);
      host.read_reg(ifs_pkg::OFS_FLAGS_A, rd_val);
      check_word(rd_val, 32'h0000_0051);
      host.write_reg(ifs_pkg::OFS_CLEAR_A, 32'h0000_0050);
      settle_check(13'h0001, 13'h0051);
      fork
         host.write_reg(ifs_pkg::OFS_CLEAR_A, 32'h0000_0200);
         pulse(13'h0200, 16'h0810);
      join
      settle_check(13'h0201, 13'h0251);
      host.read_reg(32'h0000_3030, rd_val);
      check_word(rd_val, 32'h0000_0000);
      host.read_reg(ifs_pkg::OFS_CLEAR_B, rd_val);
      check_word(rd_val, 32'h0000_0000);
      $display("sticky test done");
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      settle_check(13'h0000, 13'h0000);
      host.read_reg(ifs_pkg::OFS_DELTA, rd_val);
      check_word(rd_val, 32'h0000_ffff);
      $display("second reset test done");
      final_report();
   end
endmodule : ifs_irq_flags_tb
